// ---- hdl/devctl_pkg.sv ----
// Package of offsets, field positions and reset values for the device control and live status block.
package devctl_pkg;
	localparam logic [7:0] DEVICE_CONTROL_OFS    = 8'h0c;
	localparam logic [7:0] LIVE_EVENT_STATUS_OFS = 8'h0d;
	localparam int BIT_SOFT_RESET  = 7;
	localparam int BIT_SOFT_SYNC   = 6;
	localparam int BIT_RESERVED    = 5;
	localparam int BIT_AUTO_SYNC   = 4;
	localparam int BIT_SYNC_MUTE   = 3;
	localparam int BIT_KEEP_AON    = 2;
	localparam int BIT_PARALLEL    = 1;
	localparam int BIT_AUTO_START  = 0;
	localparam logic [7:0] DEVICE_CONTROL_RESET = 8'hd9;
	localparam logic [7:0] CONTROL_WRITE_MASK   = 8'hdf;
	localparam logic [7:0] STATUS_RESET         = 8'h00;
	// One synthesizer's live state.
	typedef struct packed {
		logic unlocked;
		logic input_lost;
		logic calibrating;
		logic back_to_primary;
	} synth_state_t;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	typedef enum logic [2:0] {
		ST_HALT  = 3'b000,
		ST_FIRST_SYNTH_CALIBRATING  = 3'b001,
		ST_SECOND_SYNTH_CALIBRATING  = 3'b010,
		ST_SYNC  = 3'b011,
		ST_RUN   = 3'b100
	} start_state_t;
endpackage

// ---- hdl/device_control_live_status.sv ----
// Device control register, live status register and start-up sequencing of a dual-synthesizer clock generator.
`timescale 1ns/100ps
// Operation
// - Writing soft reset low starts VCO recalibration.
// - Soft reset leaves register contents unchanged.
// - Soft sync low acts as external sync pin.
// - Auto sync launches sync after lock.
// - Sync mute bit mutes outputs during sync.
// - Clear keep bit moves clock to VCO.
// - Set keep bit holds always-on clock.
// - Parallel mode calibrates both synthesizers independently.
// - Parallel mode restarts second calibration independently.
// - Sequential mode calibrates second after first lock.
// - Auto start locks and enables after reset.
// - Auto start clear halts; setting it starts.
// - Live status always shows current source state.
// - Live status bits are read-only, reset zero.
// - Input loss hides loss-of-lock bit.
// - Bits one and zero show return to primary.
module device_control_live_status
(
	// Clock and reset
	input  wire logic                     REF_CLK,
	input  wire logic                     SRST,
	input  wire logic                     RESET_PIN_LOW,
	// Register port
	input  wire devctl_pkg::reg_req_t     REG_REQ,
	output logic      [7:0]               REG_RDATA,
	// Synthesizer sources and controls
	input  wire devctl_pkg::synth_state_t FIRST_SYNTH,
	input  wire devctl_pkg::synth_state_t SECOND_SYNTH,
	input  wire logic                     FIRST_SYNTH_POWERED_DOWN,
	input  wire logic                     SECOND_SYNTH_RESTART,
	input  wire logic                     SYNC_DONE,
	input  wire logic                     EXTERNAL_SYNC_PIN,
	output logic                          FIRST_CAL_START,
	output logic                          SECOND_CAL_START,
	output logic                          SYNC_ACTIVE,
	output logic                          OUTPUTS_MUTED,
	output logic                          OUTPUTS_ENABLED,
	output logic                          SYSCLK_FROM_VCO,
	output logic                          ALWAYS_ON_OSC_EN
);
	// ----------------------------------------
	// Control register
	// ----------------------------------------
	logic [7:0] ctl_q;
	logic       ctl_wr;
	logic       soft_reset_pulse;
	logic       auto_start_rise;
	logic       dev_reset;

	assign ctl_wr           = REG_REQ.wr && REG_REQ.addr == devctl_pkg::DEVICE_CONTROL_OFS;
	assign soft_reset_pulse = ctl_wr && !REG_REQ.wdata[devctl_pkg::BIT_SOFT_RESET];
	assign auto_start_rise  = ctl_wr && REG_REQ.wdata[devctl_pkg::BIT_AUTO_START]
		&& !ctl_q[devctl_pkg::BIT_AUTO_START];
	// Device reset from the pin or soft reset; the register bank itself is only cleared by SRST.
	assign dev_reset = !RESET_PIN_LOW || soft_reset_pulse;

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			ctl_q <= devctl_pkg::DEVICE_CONTROL_RESET;
		else if (ctl_wr)
			ctl_q <= (REG_REQ.wdata & devctl_pkg::CONTROL_WRITE_MASK)
				| {2'b11, 6'h00};
		else
			ctl_q <= ctl_q | {2'b11, 6'h00};
	end
	// Active-low strobe bits read back as one after their effect: they are self-restoring so a second write retriggers.

	// ----------------------------------------
	// Live status
	// ----------------------------------------
	logic [7:0] live_q;

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			live_q <= devctl_pkg::STATUS_RESET;
		else
			live_q <= {FIRST_SYNTH.unlocked && !FIRST_SYNTH.input_lost,
				FIRST_SYNTH.input_lost,
				FIRST_SYNTH.calibrating,
				SECOND_SYNTH.unlocked && !SECOND_SYNTH.input_lost,
				SECOND_SYNTH.input_lost,
				SECOND_SYNTH.calibrating,
				FIRST_SYNTH.back_to_primary,
				SECOND_SYNTH.back_to_primary};
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			REG_RDATA <= 8'h00;
		else if (REG_REQ.rd && REG_REQ.addr == devctl_pkg::DEVICE_CONTROL_OFS)
			REG_RDATA <= ctl_q & devctl_pkg::CONTROL_WRITE_MASK;
		else if (REG_REQ.rd && REG_REQ.addr == devctl_pkg::LIVE_EVENT_STATUS_OFS)
			REG_RDATA <= live_q;
		else if (REG_REQ.rd)
			REG_RDATA <= 8'h00;
	end

	// ----------------------------------------
	// Start-up sequencer
	// ----------------------------------------
	devctl_pkg::start_state_t st_q;
	devctl_pkg::start_state_t st_d;
	logic first_locked;
	logic second_locked;
	logic sync_req;
	logic sync_mode_q;
	logic boot_q;
	logic auto_now;
	logic mode_now;
	logic cal_launch;

	// A soft reset write carries its own auto start and start mode, so the written value wins over the old one.
	assign auto_now = ctl_wr ? REG_REQ.wdata[devctl_pkg::BIT_AUTO_START] : ctl_q[devctl_pkg::BIT_AUTO_START];
	assign mode_now = ctl_wr ? REG_REQ.wdata[devctl_pkg::BIT_PARALLEL] : ctl_q[devctl_pkg::BIT_PARALLEL];

	assign first_locked  = !FIRST_SYNTH.unlocked && !FIRST_SYNTH.input_lost && !FIRST_SYNTH.calibrating;
	assign second_locked = !SECOND_SYNTH.unlocked && !SECOND_SYNTH.input_lost && !SECOND_SYNTH.calibrating;
	assign sync_req = EXTERNAL_SYNC_PIN
		|| (ctl_wr && !REG_REQ.wdata[devctl_pkg::BIT_SOFT_SYNC]);

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			devctl_pkg::ST_HALT:
				if (auto_start_rise)
					st_d = devctl_pkg::ST_FIRST_SYNTH_CALIBRATING;
			devctl_pkg::ST_FIRST_SYNTH_CALIBRATING:
				if (sync_mode_q || first_locked || FIRST_SYNTH_POWERED_DOWN)
					st_d = devctl_pkg::ST_SECOND_SYNTH_CALIBRATING;
			devctl_pkg::ST_SECOND_SYNTH_CALIBRATING:
				if ((first_locked || FIRST_SYNTH_POWERED_DOWN) && second_locked)
					st_d = ctl_q[devctl_pkg::BIT_AUTO_SYNC] ? devctl_pkg::ST_SYNC
						: devctl_pkg::ST_RUN;
			devctl_pkg::ST_SYNC:
				if (SYNC_DONE)
					st_d = devctl_pkg::ST_RUN;
			devctl_pkg::ST_RUN:
				if (sync_req)
					st_d = devctl_pkg::ST_SYNC;
			default:
				st_d = devctl_pkg::ST_HALT;
		endcase
		// Device resets override the normal flow so that every launch passes through one place.
		if (boot_q)
			st_d = devctl_pkg::ST_FIRST_SYNTH_CALIBRATING;
		else if (dev_reset)
			st_d = auto_now ? devctl_pkg::ST_FIRST_SYNTH_CALIBRATING : devctl_pkg::ST_HALT;
	end

	assign cal_launch = st_d == devctl_pkg::ST_FIRST_SYNTH_CALIBRATING
		&& (st_q != devctl_pkg::ST_FIRST_SYNTH_CALIBRATING || dev_reset || boot_q);

	// The first cycle after SRST launches calibration, so power-on gives a start pulse too.
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			boot_q <= 1'b1;
		else
			boot_q <= 1'b0;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			st_q <= devctl_pkg::ST_HALT;
		else
			st_q <= st_d;
	end

	// Start mode is sampled when a sequence starts so a mid-run write cannot mix the two orders.
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
			sync_mode_q <= 1'b0;
		else if (cal_launch)
			sync_mode_q <= mode_now;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			FIRST_CAL_START  <= 1'b0;
			SECOND_CAL_START <= 1'b0;
		end
		else
		begin
			FIRST_CAL_START  <= cal_launch;
			SECOND_CAL_START <= (st_d == devctl_pkg::ST_SECOND_SYNTH_CALIBRATING && st_q == devctl_pkg::ST_FIRST_SYNTH_CALIBRATING && !sync_mode_q)
				|| (cal_launch && mode_now)
				|| (SECOND_SYNTH_RESTART && sync_mode_q);
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			SYNC_ACTIVE     <= 1'b0;
			OUTPUTS_MUTED   <= 1'b0;
			OUTPUTS_ENABLED <= 1'b0;
		end
		else
		begin
			SYNC_ACTIVE     <= st_d == devctl_pkg::ST_SYNC;
			OUTPUTS_MUTED   <= st_d == devctl_pkg::ST_SYNC && ctl_q[devctl_pkg::BIT_SYNC_MUTE];
			OUTPUTS_ENABLED <= st_d == devctl_pkg::ST_RUN
				|| (st_d == devctl_pkg::ST_SYNC && !ctl_q[devctl_pkg::BIT_SYNC_MUTE]);
		end
	end

	// The always-on oscillator is released only in run or sync with the keep bit clear, one cycle after the switch to the VCO.
	always_ff @(posedge REF_CLK)
	begin
		if (SRST || dev_reset)
		begin
			SYSCLK_FROM_VCO  <= 1'b0;
			ALWAYS_ON_OSC_EN <= 1'b1;
		end
		else if (ctl_q[devctl_pkg::BIT_KEEP_AON])
		begin
			SYSCLK_FROM_VCO  <= 1'b0;
			ALWAYS_ON_OSC_EN <= 1'b1;
		end
		else if (st_q == devctl_pkg::ST_RUN || st_q == devctl_pkg::ST_SYNC)
		begin
			SYSCLK_FROM_VCO  <= 1'b1;
			ALWAYS_ON_OSC_EN <= !SYSCLK_FROM_VCO;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	soft_reset_cal_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		soft_reset_pulse && ctl_q[devctl_pkg::BIT_AUTO_START] |=> FIRST_CAL_START)
		else $error("Soft reset did not start calibration.");
	soft_reset_keeps_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		soft_reset_pulse |=> ctl_q[5:0] == ($past(REG_REQ.wdata[5:0]) & 6'h1f))
		else $error("Soft reset altered control contents.");
	reserved_zero_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		REG_REQ.rd && REG_REQ.addr == devctl_pkg::DEVICE_CONTROL_OFS |=> !REG_RDATA[5])
		else $error("Reserved control bit read as one.");
	mute_follow_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		OUTPUTS_MUTED |-> SYNC_ACTIVE && !OUTPUTS_ENABLED)
		else $error("Muted outputs outside sync.");
	keep_aon_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		ctl_q[devctl_pkg::BIT_KEEP_AON] |=> !SYSCLK_FROM_VCO && ALWAYS_ON_OSC_EN)
		else $error("System clock left always-on oscillator.");
	los_precedence_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		FIRST_SYNTH.input_lost |=> live_q[6] && !live_q[7])
		else $error("Loss of lock shown during input loss.");
	live_track_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		!SRST |=> live_q[5:0] == {$past(FIRST_SYNTH.calibrating), $past(SECOND_SYNTH.unlocked)
			&& !$past(SECOND_SYNTH.input_lost), $past(SECOND_SYNTH.input_lost),
			$past(SECOND_SYNTH.calibrating), $past(FIRST_SYNTH.back_to_primary),
			$past(SECOND_SYNTH.back_to_primary)})
		else $error("Live status does not track sources.");
	seq_order_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		st_q == devctl_pkg::ST_FIRST_SYNTH_CALIBRATING && !sync_mode_q && !first_locked && !FIRST_SYNTH_POWERED_DOWN
		&& !dev_reset |=> st_q == devctl_pkg::ST_FIRST_SYNTH_CALIBRATING)
		else $error("Second calibration began before first lock.");
	halt_hold_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		st_q == devctl_pkg::ST_HALT && !auto_start_rise && !dev_reset && !boot_q
		|=> st_q == devctl_pkg::ST_HALT)
		else $error("Sequencer left halt without auto start.");
	boot_cal_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		boot_q |=> FIRST_CAL_START)
		else $error("Power-on did not start calibration.");
	parallel_second_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		cal_launch && mode_now |=> SECOND_CAL_START)
		else $error("Parallel mode did not start second calibration.");
	restart_second_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		SECOND_SYNTH_RESTART && sync_mode_q |=> SECOND_CAL_START)
		else $error("Second restart did not recalibrate.");
	vco_switch_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		!ctl_q[devctl_pkg::BIT_KEEP_AON] && !dev_reset && st_q == devctl_pkg::ST_RUN
		|=> SYSCLK_FROM_VCO)
		else $error("System clock not moved to VCO.");
	osc_off_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		SYSCLK_FROM_VCO && !ctl_q[devctl_pkg::BIT_KEEP_AON] && !dev_reset && st_q == devctl_pkg::ST_RUN
		|=> !ALWAYS_ON_OSC_EN)
		else $error("Always-on oscillator left running.");
	unmuted_run_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		SYNC_ACTIVE && !OUTPUTS_MUTED |-> OUTPUTS_ENABLED)
		else $error("Unmuted sync disabled outputs.");
	pin_sync_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		st_q == devctl_pkg::ST_RUN && EXTERNAL_SYNC_PIN && !dev_reset |=> SYNC_ACTIVE)
		else $error("Sync pin ignored in run.");
	auto_sync_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		st_q == devctl_pkg::ST_SECOND_SYNTH_CALIBRATING && first_locked && second_locked
		&& ctl_q[devctl_pkg::BIT_AUTO_SYNC] && !dev_reset |=> SYNC_ACTIVE)
		else $error("Auto sync not launched after lock.");
	halt_quiet_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		st_q == devctl_pkg::ST_HALT |-> !OUTPUTS_ENABLED && !SYNC_ACTIVE)
		else $error("Outputs active while halted.");
endmodule

// ---- tb/device_control_live_status_tb.sv ----
// Self-checking testbench for the device control and live status block.
`timescale 1ns/100ps
module device_control_live_status_tb;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic                     REF_CLK                  = 1'b0;
	logic                     SRST                     = 1'b1;
	logic                     RESET_PIN_LOW            = 1'b1;
	devctl_pkg::reg_req_t     REG_REQ                  = '0;
	devctl_pkg::synth_state_t FIRST_SYNTH              = 4'h8;
	devctl_pkg::synth_state_t SECOND_SYNTH             = 4'h8;
	logic                     FIRST_SYNTH_POWERED_DOWN = 1'b0;
	logic                     SECOND_SYNTH_RESTART     = 1'b0;
	logic                     SYNC_DONE                = 1'b0;
	logic                     EXTERNAL_SYNC_PIN        = 1'b0;
	logic [7:0]               REG_RDATA;
	logic                     FIRST_CAL_START;
	logic                     SECOND_CAL_START;
	logic                     SYNC_ACTIVE;
	logic                     OUTPUTS_MUTED;
	logic                     OUTPUTS_ENABLED;
	logic                     SYSCLK_FROM_VCO;
	logic                     ALWAYS_ON_OSC_EN;
	logic [4:0]               obs;
	int                       num_errors = 0;
	int                       n_checks   = 0;
	int                       cycles     = 0;
	int                       n_first    = 0;
	int                       n_second   = 0;

	assign obs = {SYNC_ACTIVE, OUTPUTS_MUTED, OUTPUTS_ENABLED, SYSCLK_FROM_VCO, ALWAYS_ON_OSC_EN};

	device_control_live_status DUT
	(
		.REF_CLK(REF_CLK), .SRST(SRST), .RESET_PIN_LOW(RESET_PIN_LOW),
		.REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
		.FIRST_SYNTH(FIRST_SYNTH), .SECOND_SYNTH(SECOND_SYNTH),
		.FIRST_SYNTH_POWERED_DOWN(FIRST_SYNTH_POWERED_DOWN), .SECOND_SYNTH_RESTART(SECOND_SYNTH_RESTART),
		.SYNC_DONE(SYNC_DONE), .EXTERNAL_SYNC_PIN(EXTERNAL_SYNC_PIN),
		.FIRST_CAL_START(FIRST_CAL_START), .SECOND_CAL_START(SECOND_CAL_START),
		.SYNC_ACTIVE(SYNC_ACTIVE), .OUTPUTS_MUTED(OUTPUTS_MUTED), .OUTPUTS_ENABLED(OUTPUTS_ENABLED),
		.SYSCLK_FROM_VCO(SYSCLK_FROM_VCO), .ALWAYS_ON_OSC_EN(ALWAYS_ON_OSC_EN)
	);

	always #12.5 REF_CLK = ~REF_CLK;

	// Calibration strobes last one cycle, so they are counted rather than waited for.
	always @(posedge REF_CLK)
	begin
		cycles <= cycles + 1;
		if (FIRST_CAL_START === 1'b1)
			n_first <= n_first + 1;
		if (SECOND_CAL_START === 1'b1)
			n_second <= n_second + 1;
		if (cycles == 3000)
		begin
			num_errors++;
			end_of_test();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string s, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge REF_CLK);
		REG_REQ = '{1'b1, 1'b0, a, d};
		@(negedge REF_CLK);
		REG_REQ = '0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string s);
		@(negedge REF_CLK);
		REG_REQ = '{1'b0, 1'b1, a, 8'h00};
		@(negedge REF_CLK);
		REG_REQ = '0;
		@(negedge REF_CLK);
		check(s, REG_RDATA, exp);
	endtask

	task automatic wait_lvl(input int i, input logic v, input string s);
		int k = 0;
		while (obs[i] !== v && k < 40)
		begin
			@(negedge REF_CLK);
			k++;
		end
		check(s, 8'(obs[i]), 8'(v));
	endtask

	task automatic done_sync;
		SYNC_DONE = 1'b1;
		@(negedge REF_CLK);
		SYNC_DONE = 1'b0;
		wait_lvl(4, 1'b0, "sync end");
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_start;
		rchk(8'h0c, 8'hd9, "control reset");
		check("first cal", 8'(n_first), 8'h01);
		check("second held", 8'(n_second), 8'h00);
		FIRST_SYNTH = 4'h0;
		repeat (8) @(negedge REF_CLK);
		check("second cal", 8'(n_second), 8'h01);
		SECOND_SYNTH = 4'h0;
		wait_lvl(4, 1'b1, "auto sync");
		check("sync muted", 8'(OUTPUTS_MUTED), 8'h01);
		done_sync();
		wait_lvl(2, 1'b1, "enabled");
		wait_lvl(0, 1'b0, "osc off");
		check("vco clock", 8'(SYSCLK_FROM_VCO), 8'h01);
		$display("start test done");
	endtask

	task automatic t_sync;
		wr(8'h0c, 8'hd1);
		wr(8'h0c, 8'h91);
		wait_lvl(4, 1'b1, "soft sync");
		check("not muted", 8'(OUTPUTS_MUTED), 8'h00);
		done_sync();
		wr(8'h0c, 8'hd9);
		EXTERNAL_SYNC_PIN = 1'b1;
		wait_lvl(4, 1'b1, "pin sync");
		check("pin muted", 8'(OUTPUTS_MUTED), 8'h01);
		EXTERNAL_SYNC_PIN = 1'b0;
		done_sync();
		$display("sync test done");
	endtask

	task automatic t_regs;
		wr(8'h0c, 8'hfb);
		rchk(8'h0c, 8'hdb, "reserved bit");
		FIRST_SYNTH = 4'he;
		SECOND_SYNTH = 4'h3;
		wr(8'h0d, 8'h00);
		rchk(8'h0d, 8'h65, "status a");
		FIRST_SYNTH = 4'h9;
		SECOND_SYNTH = 4'hc;
		rchk(8'h0d, 8'h8a, "status b");
		rchk(8'h33, 8'h00, "unmapped");
		FIRST_SYNTH = 4'h8;
		$display("register test done");
	endtask

	task automatic t_soft;
		int a = n_first;
		int b = n_second;
		wr(8'h0c, 8'h5b);
		repeat (6) @(negedge REF_CLK);
		check("soft cal", 8'(n_first - a), 8'h01);
		check("parallel cal", 8'(n_second - b), 8'h01);
		rchk(8'h0c, 8'hdb, "regs kept");
		SECOND_SYNTH_RESTART = 1'b1;
		@(negedge REF_CLK);
		SECOND_SYNTH_RESTART = 1'b0;
		repeat (4) @(negedge REF_CLK);
		check("restart cal", 8'(n_second - b), 8'h02);
		$display("soft reset test done");
	endtask

	// With auto start clear the pin reset must halt, and only the write of the bit restarts.
	task automatic t_halt;
		int a;
		wr(8'h0c, 8'hde);
		a = n_first;
		RESET_PIN_LOW = 1'b0;
		@(negedge REF_CLK);
		RESET_PIN_LOW = 1'b1;
		repeat (8) @(negedge REF_CLK);
		check("halted", 8'(n_first - a), 8'h00);
		wr(8'h0c, 8'hdf);
		repeat (4) @(negedge REF_CLK);
		check("write start", 8'(n_first - a), 8'h01);
		FIRST_SYNTH = 4'h0;
		SECOND_SYNTH = 4'h0;
		wait_lvl(4, 1'b1, "auto sync again");
		done_sync();
		wait_lvl(2, 1'b1, "enabled again");
		check("osc kept", 8'(ALWAYS_ON_OSC_EN), 8'h01);
		check("no vco", 8'(SYSCLK_FROM_VCO), 8'h00);
		$display("halt test done");
	endtask

	initial
	begin
		repeat (5) @(negedge REF_CLK);
		SRST = 1'b0;
		t_start();
		t_sync();
		t_regs();
		t_soft();
		t_halt();
		end_of_test();
	end
endmodule
